// file: hw/pfd_outputs.sv
// phase comparator outputs: pump drive, monitor pin and fast-lock switch
// What this block and its surroundings do
// RQ1 - ref faster: pump sense per polarity
// RQ2 - comparison faster: pump sense per polarity
// RQ3 - equal: pump float, up low, down float
// RQ4 - polarity picks monitor source, inverts pump
// RQ5 - controller sets polarity from VCO slope
// RQ6 - phase detection spans minus to plus 2pi
// RQ7 - short pump pulse at coincidence, no deadband
// RQ8 - strobe high: fast-lock switch shows pump
// RQ9 - strobe low: fast-lock pin floats
// RQ10 - strobe open reads high via pull-up
// RQ11 - track every edge, outputs combinational except the registered monitor
`timescale 1ns/10ps
`default_nettype none
`include "pfd_map.svh"
module pfd_outputs (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic divided_reference_i,
    input wire logic divided_comparison_i,
    input wire logic polarity_select_i,
    input wire logic load_latch_strobe_i,
    output logic pump_o,
    output logic pump_oe_o,
    output logic pump_up_o,
    output logic pump_dn_o,
    output logic pump_dn_oe_o,
    output logic divider_monitor_out_o,
    output logic fast_lock_switch_out_o,
    output logic fast_lock_switch_out_oe_o
);
    pfd_if pd();
    logic mon_reg, mon_next;

    pfd_tracker u_tracker (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .divided_reference_i(divided_reference_i),
        .divided_comparison_i(divided_comparison_i),
        .pd(pd)
    );

    // pump table; polarity (pull-up, RQ5 left to controller) flips sense
    always_comb
    begin
        pump_o = 1'b0;
        pump_oe_o = 1'b0;
        pump_up_o = 1'b0;
        pump_dn_o = 1'b0;
        pump_dn_oe_o = 1'b0;
        case (pd.state)
            pfd_pkg::PD_REF_FAST:
            begin
                pump_oe_o = 1'b1; // RQ1
                pump_o = polarity_select_i; // RQ1 RQ4
                pump_up_o = ~polarity_select_i; // RQ1
                pump_dn_oe_o = polarity_select_i; // RQ1 low drive only when high
            end
            pfd_pkg::PD_CMP_FAST:
            begin
                pump_oe_o = 1'b1; // RQ2
                pump_o = ~polarity_select_i; // RQ2 RQ4
                pump_up_o = polarity_select_i; // RQ2
                pump_dn_oe_o = ~polarity_select_i; // RQ2
            end
            pfd_pkg::PD_EQUAL:
            begin
                // floating at lock; spike drives both pump lines briefly
                pump_oe_o = pd.spike; // RQ3 RQ7
                pump_dn_oe_o = pd.spike; // RQ3 RQ7
            end
            default:
            begin
                pump_oe_o = 1'b0;
            end
        endcase
    end

    // monitor is registered, one cycle behind the chosen divider
    always_comb
    begin
        mon_next = polarity_select_i ? divided_reference_i : divided_comparison_i; // RQ4
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            mon_reg <= 1'b0;
        else if (ce_i)
            mon_reg <= mon_next;
    end

    assign divider_monitor_out_o = mon_reg;
    // analog switch: strobe pin's pull-up is external to this logic
    assign fast_lock_switch_out_oe_o = load_latch_strobe_i; // RQ8 RQ9 RQ10
    assign fast_lock_switch_out_o = load_latch_strobe_i & pump_o; // RQ8

    // fast-lock switch: closed only while the strobe stands high
    switch_on_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ8
        load_latch_strobe_i |-> fast_lock_switch_out_oe_o && fast_lock_switch_out_o == pump_o)
        else $error("fast-lock switch not passing pump");

    switch_off_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ9
        !load_latch_strobe_i |-> !fast_lock_switch_out_oe_o)
        else $error("fast-lock pin driven while strobe low");

    // an open switch leaves no stale level behind for the pad
    switch_idle_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ9
        !load_latch_strobe_i |-> !fast_lock_switch_out_o)
        else $error("fast-lock level left while switch open");

    // the pad pull-up turns an open strobe into a high, so the enable follows the pin as is
    switch_follow_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ10
        fast_lock_switch_out_oe_o == load_latch_strobe_i)
        else $error("fast-lock enable not following strobe");

    // pump drive against the comparator state
    ref_fast_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ1
        pd.state == pfd_pkg::PD_REF_FAST |-> pump_oe_o && pump_o == polarity_select_i
        && pump_up_o == !polarity_select_i)
        else $error("pump wrong with reference fast");

    cmp_fast_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ2
        pd.state == pfd_pkg::PD_CMP_FAST |-> pump_oe_o && pump_o == !polarity_select_i
        && pump_dn_oe_o == !polarity_select_i)
        else $error("pump wrong with comparison fast");

    // one table row each, written as fixed levels so a sense slip cannot cancel out
    ref_fast_hi_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ1
        (pd.state == pfd_pkg::PD_REF_FAST && polarity_select_i)
        |-> pump_oe_o && pump_o && !pump_up_o && pump_dn_oe_o)
        else $error("reference fast with polarity high: wrong levels");

    ref_fast_lo_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ1
        (pd.state == pfd_pkg::PD_REF_FAST && !polarity_select_i)
        |-> pump_oe_o && !pump_o && pump_up_o && !pump_dn_oe_o)
        else $error("reference fast with polarity low: wrong levels");

    cmp_fast_hi_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ2
        (pd.state == pfd_pkg::PD_CMP_FAST && polarity_select_i)
        |-> pump_oe_o && !pump_o && pump_up_o && !pump_dn_oe_o)
        else $error("comparison fast with polarity high: wrong levels");

    cmp_fast_lo_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ2
        (pd.state == pfd_pkg::PD_CMP_FAST && !polarity_select_i)
        |-> pump_oe_o && pump_o && !pump_up_o && pump_dn_oe_o)
        else $error("comparison fast with polarity low: wrong levels");

    // at lock, outside the coincidence spike, everything floats except the up line, which rests low
    equal_float_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ3
        (pd.state == pfd_pkg::PD_EQUAL && !pd.spike) |-> !pump_oe_o && !pump_up_o && !pump_dn_oe_o)
        else $error("pump not floating at lock");

    up_low_equal_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ3
        pd.state == pfd_pkg::PD_EQUAL |-> !pump_up_o)
        else $error("up line high at lock");

    // an undriven pump keeps its level low so the fast-lock copy stays quiet too
    pump_rest_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ3
        !pump_oe_o |-> !pump_o)
        else $error("pump level set while released");

    // the open-drain down line can only pull low
    dn_data_low_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ1
        !pump_dn_o)
        else $error("down line data not low");

    // coincidence pulse: pump and down line pull low together, up stays low
    spike_shape_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ7
        (pd.state == pfd_pkg::PD_EQUAL && pd.spike)
        |-> pump_oe_o && !pump_o && !pump_up_o && pump_dn_oe_o)
        else $error("coincidence pulse has wrong levels");

    // flipping polarity mid-lead must flip the pump level at once
    pol_flip_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ4
        (pd.state != pfd_pkg::PD_EQUAL && $stable(pd.state) && $changed(polarity_select_i))
        |-> $changed(pump_o))
        else $error("pump sense did not follow polarity");

    // the edge after reset release reloads the register, so skip it
    monitor_sel_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ4
        (ce_i && $past(ce_i) && !$past(rst_i)) |-> divider_monitor_out_o ==
        ($past(polarity_select_i) ? $past(divided_reference_i) : $past(divided_comparison_i)))
        else $error("monitor source wrong");

    // clock enable low freezes the monitor and the comparator state
    monitor_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ11
        !ce_i |=> $stable(divider_monitor_out_o))
        else $error("monitor moved while enable low");

    state_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ11
        !ce_i |=> $stable(pd.state) && $stable(pd.spike))
        else $error("comparator state moved while enable low");

    // scenarios worth seeing at least once
    switch_cov: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        load_latch_strobe_i && pump_oe_o);
    spike_cov: cover property (@(posedge ref_clk_i) disable iff (rst_i) pd.spike);
    inv_cov: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        !polarity_select_i && pd.state == pfd_pkg::PD_CMP_FAST);
endmodule
`default_nettype wire

// file: hw/pfd_map.svh
// constants for the phase comparator output block
`ifndef PFD_MAP_SVH
`define PFD_MAP_SVH
`define PFD_CNT_W 2
`define PFD_CNT_MAX 2'h3
`define PFD_CNT_ZERO 2'h0
`define PFD_CNT_ONE 2'h1
`define PFD_SPIKE_CYC 1
`endif

// file: hw/pfd_pkg.sv
// types for the phase comparator output block
`default_nettype none
package pfd_pkg;
    typedef enum logic [1:0] {
        PD_EQUAL = 2'b00,
        PD_REF_FAST = 2'b01,
        PD_CMP_FAST = 2'b10
    } pd_state_t;
endpackage
`default_nettype wire

// file: hw/pfd_if.sv
// comparator state carried from the edge tracker to the output stage
`timescale 1ns/10ps
`default_nettype none
interface pfd_if;
    pfd_pkg::pd_state_t state;
    logic spike;
    modport tracker (output state, output spike);
    modport user (input state, input spike);
endinterface
`default_nettype wire

// file: hw/pfd_tracker.sv
// edge tracker: signed phase count between the two divided signals
`timescale 1ns/10ps
`default_nettype none
`include "pfd_map.svh"
module pfd_tracker (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic divided_reference_i,
    input wire logic divided_comparison_i,
    pfd_if.tracker pd
);
    logic ref_d_reg, ref_d_next, cmp_d_reg, cmp_d_next;
    logic [`PFD_CNT_W-1:0] up_reg, up_next, dn_reg, dn_next;
    logic spike_reg, spike_next;
    logic ref_rise, cmp_rise;

    assign ref_rise = divided_reference_i & ~ref_d_reg;
    assign cmp_rise = divided_comparison_i & ~cmp_d_reg;

    // saturating counters span -2pi..+2pi, two edges of margin each way
    always_comb
    begin
        ref_d_next = divided_reference_i;
        cmp_d_next = divided_comparison_i;
        up_next = up_reg;
        dn_next = dn_reg;
        spike_next = 1'b0;
        if (ref_rise && !cmp_rise) // RQ11
        begin
            if (dn_reg != `PFD_CNT_ZERO)
            begin
                dn_next = dn_reg - 1'b1;
                spike_next = (dn_reg == `PFD_CNT_ONE); // RQ7
            end
            else if (up_reg != `PFD_CNT_MAX)
                up_next = up_reg + 1'b1; // RQ6
        end
        else if (cmp_rise && !ref_rise) // RQ11
        begin
            if (up_reg != `PFD_CNT_ZERO)
            begin
                up_next = up_reg - 1'b1;
                spike_next = (up_reg == `PFD_CNT_ONE); // RQ7
            end
            else if (dn_reg != `PFD_CNT_MAX)
                dn_next = dn_reg + 1'b1; // RQ6
        end
        else if (ref_rise && cmp_rise)
            spike_next = 1'b1; // RQ7 coincident edges still pulse
    end

    // registers; clock enable freezes all state
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ref_d_reg <= 1'b0;
            cmp_d_reg <= 1'b0;
            up_reg <= `PFD_CNT_ZERO;
            dn_reg <= `PFD_CNT_ZERO;
            spike_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            ref_d_reg <= ref_d_next;
            cmp_d_reg <= cmp_d_next;
            up_reg <= up_next;
            dn_reg <= dn_next;
            spike_reg <= spike_next;
        end
    end

    assign pd.state = (up_reg != `PFD_CNT_ZERO) ? pfd_pkg::PD_REF_FAST :
                      (dn_reg != `PFD_CNT_ZERO) ? pfd_pkg::PD_CMP_FAST : pfd_pkg::PD_EQUAL;
    assign pd.spike = spike_reg;

    up_dn_excl_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ6
        !((up_reg != `PFD_CNT_ZERO) && (dn_reg != `PFD_CNT_ZERO)))
        else $error("both phase counters nonzero");
    ref_lead_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ11
        (ce_i && ref_rise && !cmp_rise && dn_reg == `PFD_CNT_ZERO && up_reg == `PFD_CNT_ZERO)
        |=> pd.state == pfd_pkg::PD_REF_FAST)
        else $error("reference lead not tracked");
    cmp_lead_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ11
        (ce_i && cmp_rise && !ref_rise && dn_reg == `PFD_CNT_ZERO && up_reg == `PFD_CNT_ZERO)
        |=> pd.state == pfd_pkg::PD_CMP_FAST)
        else $error("comparison lead not tracked");
    spike_one_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ7
        (ce_i && spike_reg) |=> !spike_reg)
        else $error("spike longer than one cycle");
    lead_cov: cover property (@(posedge ref_clk_i) disable iff (rst_i) up_reg == `PFD_CNT_MAX);
    lag_cov: cover property (@(posedge ref_clk_i) disable iff (rst_i) dn_reg == `PFD_CNT_MAX);
endmodule
`default_nettype wire

// file: sim/ext_pump_model.sv
// far-side model: external pump lines as the loop filter sees them
`timescale 1ns/10ps
`default_nettype none
module ext_pump_model (
    input wire logic ref_clk_i,
    input wire logic pump_o_i,
    input wire logic pump_oe_i,
    input wire logic pump_dn_oe_i,
    output logic dn_line_o,
    output logic pump_line_o
);
    logic last_reg = 1'b0;
    // released pump node shows the inverse of its last drive, so a float never reads as stale
    always @(posedge ref_clk_i)
        if (pump_oe_i)
            last_reg <= pump_o_i;
    // open-drain down line: external pull-up wins when the device lets go
    assign dn_line_o = pump_dn_oe_i ? 1'b0 : 1'b1;
    assign pump_line_o = pump_oe_i ? pump_o_i : !last_reg;
endmodule
`default_nettype wire

// file: sim/pfd_outputs_tb.sv
// self-checking bench for the phase comparator output block
`timescale 1ns/10ps
`default_nettype none
module pfd_outputs_tb;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ref_in = 1'b0;
    logic cmp_in = 1'b0;
    logic pol = 1'b1;
    logic strb = 1'b1;
    logic ce = 1'b1;
    logic pump_o, pump_oe_o, pump_up_o, pump_dn_o, pump_dn_oe_o;
    logic divider_monitor_out_o, fast_lock_switch_out_o, fast_lock_switch_out_oe_o;
    logic dn_line, pump_line;
    int n_fail = 0;
    int comparisons = 0;
    // 40 MHz clock
    always #12.5 ref_clk_i = !ref_clk_i;
    pfd_outputs u_pfd_outputs (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce),
        .divided_reference_i(ref_in), .divided_comparison_i(cmp_in), .polarity_select_i(pol),
        .load_latch_strobe_i(strb), .pump_o(pump_o), .pump_oe_o(pump_oe_o), .pump_up_o(pump_up_o),
        .pump_dn_o(pump_dn_o), .pump_dn_oe_o(pump_dn_oe_o), .divider_monitor_out_o(divider_monitor_out_o),
        .fast_lock_switch_out_o(fast_lock_switch_out_o), .fast_lock_switch_out_oe_o(fast_lock_switch_out_oe_o));
    ext_pump_model u_ext_pump_model (.ref_clk_i(ref_clk_i), .pump_o_i(pump_o), .pump_oe_i(pump_oe_o),
        .pump_dn_oe_i(pump_dn_oe_o), .dn_line_o(dn_line), .pump_line_o(pump_line));
    // pump view: {drive enable, driven level, up, down pulled low}
    function automatic logic [3:0] obs(input logic sel);
        if (!sel)
            return {pump_oe_o, pump_line & pump_oe_o, pump_up_o, !dn_line};
        return {divider_monitor_out_o, fast_lock_switch_out_oe_o,
                fast_lock_switch_out_o & fast_lock_switch_out_oe_o, 1'b0};
    endfunction
    // bounded wait for the expected view; latency is the design's choice
    task automatic expect_out(input string what, input logic sel, input logic [3:0] exp, input int tries);
        logic [3:0] seen;
        begin
            seen = 4'h0;
            for (int i = 0; i < tries; i++)
            begin
                @(negedge ref_clk_i);
                seen = obs(sel);
                if (seen === exp)
                    break;
            end
            comparisons++;
            if (seen !== exp)
            begin
                n_fail++;
                $display("[ERR] %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // one input leads, the other catches up: lead drive, spike, then float
    task automatic lead(input logic p, input logic ref_first, input logic s);
        logic [3:0] lv;
        begin
            lv = (p == ref_first) ? 4'hD : 4'hA;
            @(posedge ref_clk_i);
            pol <= p;
            strb <= s;
            @(posedge ref_clk_i);
            if (ref_first)
                ref_in <= 1'b1;
            else
                cmp_in <= 1'b1;
            expect_out("lead_drive", 1'b0, lv, 4);
            expect_out("monitor_switch", 1'b1, {p == ref_first, s, s & lv[2], 1'b0}, 4);
            @(posedge ref_clk_i);
            if (ref_first)
                cmp_in <= 1'b1;
            else
                ref_in <= 1'b1;
            expect_out("spike", 1'b0, 4'h9, 4);
            expect_out("equal_float", 1'b0, 4'h0, 1);
            @(posedge ref_clk_i);
            ref_in <= 1'b0;
            cmp_in <= 1'b0;
            repeat (3) @(posedge ref_clk_i);
        end
    endtask
    // enable low: a reference edge must neither count nor reach the monitor; then flip polarity mid-lead
    task automatic freeze_flip;
        begin
            @(posedge ref_clk_i);
            pol <= 1'b1;
            strb <= 1'b0;
            ce <= 1'b0;
            @(posedge ref_clk_i);
            ref_in <= 1'b1;
            repeat (3) @(posedge ref_clk_i);
            expect_out("frozen_pump", 1'b0, 4'h0, 1);
            expect_out("frozen_monitor", 1'b1, 4'h0, 1);
            @(posedge ref_clk_i);
            ce <= 1'b1;
            expect_out("thawed_pump", 1'b0, 4'hD, 4);
            expect_out("thawed_monitor", 1'b1, 4'h8, 1);
            @(posedge ref_clk_i);
            pol <= 1'b0;
            expect_out("flipped_pump", 1'b0, 4'hA, 1);
            @(posedge ref_clk_i);
            cmp_in <= 1'b1;
            expect_out("flipped_spike", 1'b0, 4'h9, 4);
            @(posedge ref_clk_i);
            ref_in <= 1'b0;
            cmp_in <= 1'b0;
            repeat (3) @(posedge ref_clk_i);
        end
    endtask
    task automatic close_out;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, n_fail);
            if (n_fail == 0 && comparisons > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    // main sequence: every polarity with both leading inputs
    initial
    begin
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        for (int i = 0; i < 4; i++)
            lead(i[0], i[1], i[1]);
        freeze_flip();
        close_out();
    end
    // watchdog: the run needs well under 200 cycles
    initial
    begin
        #(25 * 2000);
        n_fail++;
        close_out();
    end
endmodule
`default_nettype wire
